//--- logic/irq_ctrl_regs.vh
// constants for the interrupt control core: register offsets, bit positions, vector, shadow map
// assumes the core uses the names only, while the bench also repeats some figures such as bank 5'h1f
`ifndef IRQ_CTRL_REGS_VH
`define IRQ_CTRL_REGS_VH
`define ADDR_W 4
`define OFS_IRQ_CONTROL 4'h0
`define OFS_SHD_ACC 4'h1
`define OFS_SHD_STATUS 4'h2
`define OFS_SHD_BANK_SEL 4'h3
`define OFS_SHD_PTR_LO 4'h4
`define OFS_SHD_PTR_HI 4'h5
`define OFS_SHD_PCH 4'h6
`define OFS_OPTION 4'h7
`define OFS_CORE_STATE 4'h8
`define SHADOW_BANK 5'h1f
`define IRQ_CONTROL_RESET 8'h00
`define BIT_GLOBAL_EN 7
`define BIT_PERIPH_EN 6
`define BIT_T0IE 5
`define BIT_EXTIE 4
`define BIT_PCIE 3
`define BIT_T0IF 2
`define BIT_EXTIF 1
`define BIT_PCIF 0
`define BIT_EDGE 0
`define BIT_WAKE_EN 1
`define STATUS_KEEP_MASK 8'he7
`define STATUS_TOPD_MASK 8'h18
`define IRQ_VECTOR 15'h0004
`define NOP_CYCLES 2'd2
`endif

//--- logic/irq_ctrl_core.v
// interrupt control core: control register, external pin edge detect, sleep wake,
// vectoring sequencer and automatic context shadowing.
// assumes the core gives a one-cycle Q1 strobe per instruction cycle, a retire
// strobe at each instruction end and a return strobe when it executes the return.
//
// How it works
// - wake only from clockless sources whose enables were set before sleep.
// - on wake, vector if global enable set, else continue after sleep.
// - the instruction after sleep always executes before vectoring.
// - external pin gives an asynchronous edge request, gated by its enable.
// - edge select one picks rising edge, zero picks falling edge.
// - valid edge sets the pin flag; with both enables it vectors.
// - pin flag may set anywhere across Q4 through following Q1.
// - on entry push return pc and copy five context registers to shadows.
// - saved status excludes the watchdog-timeout and power-down bits.
// - on return the shadows are restored, discarding routine changes.
// - shadows read and write in bank 31; written values get restored.
// - flags set on their condition regardless of any enable.
// - bit 7 is global enable; zero blocks every interrupt.
// - bit 6 is peripheral enable, gating all peripheral requests.
// - bit 5 enables timer0 overflow; bit 2 is its flag.
// - bit 4 enables the external pin interrupt; bit 1 is its flag.
// - bit 3 enables pin change; bit 0 flags any pin change pending.
// - pin change flag read-only, clears when all individual flags cleared.
// - all bits reset to zero; bits 7..1 read-write, bit 0 read-only.
// - taking an irq flushes prefetch, clears global enable, pushes, saves, vectors.
// - return pops, restores context and sets global enable again.
// - latency three or four cycles synchronous, three to five asynchronous.
// - irq arriving while global enable clear stays pending till set.
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "irq_ctrl_regs.vh"
module irq_ctrl_core (
  input wire SYS_CLK,
  input wire RSTN,
  input wire [`ADDR_W-1:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire [4:0] BANK,
  input wire EXT_PIN,
  input wire TIMER0_OVF,
  input wire PIN_CHANGE_ANY,
  input wire PERIPH_REQ,
  input wire Q1,
  input wire RETIRE,
  input wire RETURN_EXEC,
  input wire SLEEP_ENTER,
  input wire [14:0] PC_RETURN,
  input wire [7:0] LIVE_ACC,
  input wire [7:0] LIVE_STATUS,
  input wire [7:0] LIVE_BANK_SEL,
  input wire [15:0] LIVE_IND_PTR,
  input wire [7:0] LIVE_PCH,
  output reg ASLEEP,
  output reg WAKE,
  output reg FLUSH,
  output reg FORCE_NOP,
  output reg PUSH,
  output reg [14:0] PUSH_PC,
  output reg POP,
  output reg LOAD_PC,
  output reg [14:0] NEW_PC,
  output reg RESTORE,
  output reg [7:0] RESTORE_ACC,
  output reg [7:0] RESTORE_STATUS,
  output reg [7:0] RESTORE_BANK_SEL,
  output reg [15:0] RESTORE_IND_PTR,
  output reg [7:0] RESTORE_PCH
);
  localparam ST_RUN = 2'd0;
  localparam ST_SLEEP = 2'd1;
  localparam ST_POSTWAKE = 2'd2;
  localparam ST_VECTOR = 2'd3;

  reg [7:0] ctrl;
  reg [1:0] option;
  reg ext_s1, ext_s2, ext_prev;
  reg pc_s1, pc_s2;
  reg [1:0] state;
  reg [1:0] nop_cnt;
  reg [7:0] shd_acc, shd_status, shd_bank_sel, shd_pch;
  reg [15:0] shd_ind_ptr;
  reg [1:0] sleep_en;
  reg take_pending;

  wire shadow_sel = (BANK == `SHADOW_BANK);
  wire wr_ctrl = WR && (ADDR == `OFS_IRQ_CONTROL);
  // pin is async: two flops before the edge detector
  wire ext_rise = ext_s2 && !ext_prev;
  wire ext_fall = !ext_s2 && ext_prev;
  wire ext_edge = option[`BIT_EDGE] ? ext_rise : ext_fall;
  wire global_en = ctrl[`BIT_GLOBAL_EN];
  wire periph_req = ctrl[`BIT_PERIPH_EN] && PERIPH_REQ;
  wire any_req = (ctrl[`BIT_T0IE] && ctrl[`BIT_T0IF]) ||
                 (ctrl[`BIT_EXTIE] && ctrl[`BIT_EXTIF]) ||
                 (ctrl[`BIT_PCIE] && ctrl[`BIT_PCIF]) ||
                 periph_req;
  // wake needs only individual enables; timer0 stops in sleep so it cannot wake
  wire wake_req = (sleep_en[0] && ctrl[`BIT_EXTIE] && ctrl[`BIT_EXTIF]) ||
                  (sleep_en[1] && ctrl[`BIT_PCIE] && ctrl[`BIT_PCIF]) ||
                  periph_req;

  always @(posedge SYS_CLK) begin
    if (!RSTN) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_prev <= 1'b0;
      pc_s1 <= 1'b0;
      pc_s2 <= 1'b0;
    end else begin
      ext_s1 <= EXT_PIN;
      ext_s2 <= ext_s1;
      ext_prev <= ext_s2;
      pc_s1 <= PIN_CHANGE_ANY;
      pc_s2 <= pc_s1;
    end
  end

  // control register; hardware set wins over a software clear in the same cycle
  always @(posedge SYS_CLK) begin
    if (!RSTN) begin
      ctrl <= `IRQ_CONTROL_RESET;
      option <= 2'b00;
    end else begin
      if (wr_ctrl)
        ctrl[7:1] <= WDATA[7:1];
      if (WR && ADDR == `OFS_OPTION)
        option <= WDATA[1:0];
      // edge flag sets in any cycle, so Q4..Q1 is covered
      if (ext_edge)
        ctrl[`BIT_EXTIF] <= 1'b1;
      if (TIMER0_OVF)
        ctrl[`BIT_T0IF] <= 1'b1;
      ctrl[`BIT_PCIF] <= pc_s2;
      if (state == ST_RUN && Q1 && global_en && any_req)
        ctrl[`BIT_GLOBAL_EN] <= 1'b0;
      else if (RETURN_EXEC && state == ST_RUN)
        ctrl[`BIT_GLOBAL_EN] <= 1'b1;
    end
  end

  // sequencer: sample at Q1, retire the current instruction, then nop slots
  always @(posedge SYS_CLK) begin
    if (!RSTN) begin
      state <= ST_RUN;
      nop_cnt <= 2'd0;
      take_pending <= 1'b0;
      sleep_en <= 2'b00;
      ASLEEP <= 1'b0;
      WAKE <= 1'b0;
      FLUSH <= 1'b0;
      FORCE_NOP <= 1'b0;
      PUSH <= 1'b0;
      PUSH_PC <= 15'h0000;
      LOAD_PC <= 1'b0;
      NEW_PC <= 15'h0000;
      shd_acc <= 8'h00;
      shd_status <= 8'h00;
      shd_bank_sel <= 8'h00;
      shd_ind_ptr <= 16'h0000;
      shd_pch <= 8'h00;
    end else begin
      WAKE <= 1'b0;
      FLUSH <= 1'b0;
      PUSH <= 1'b0;
      LOAD_PC <= 1'b0;
      case (state)
        ST_RUN: begin
          // pending request waits here until global enable returns
          if (Q1 && global_en && any_req) begin
            take_pending <= 1'b1;
          end else if (SLEEP_ENTER) begin
            state <= ST_SLEEP;
            ASLEEP <= 1'b1;
            sleep_en <= {ctrl[`BIT_PCIE], ctrl[`BIT_EXTIE]};
          end
          if (take_pending && RETIRE) begin
            take_pending <= 1'b0;
            state <= ST_VECTOR;
            FLUSH <= 1'b1;
            FORCE_NOP <= 1'b1;
            nop_cnt <= `NOP_CYCLES;
            PUSH <= 1'b1;
            PUSH_PC <= PC_RETURN;
            shd_acc <= LIVE_ACC;
            shd_status <= LIVE_STATUS & `STATUS_KEEP_MASK;
            shd_bank_sel <= LIVE_BANK_SEL;
            shd_ind_ptr <= LIVE_IND_PTR;
            shd_pch <= LIVE_PCH;
          end
        end
        ST_SLEEP: begin
          if (wake_req) begin
            ASLEEP <= 1'b0;
            WAKE <= 1'b1;
            state <= ST_POSTWAKE;
          end
        end
        ST_POSTWAKE: begin
          if (RETIRE) begin
            state <= ST_RUN; // vectors via the run state when gie is set
          end
        end
        default: begin
          if (Q1) begin
            if (nop_cnt == 2'd1) begin
              FORCE_NOP <= 1'b0;
              LOAD_PC <= 1'b1;
              NEW_PC <= `IRQ_VECTOR;
              state <= ST_RUN;
            end
            nop_cnt <= nop_cnt - 2'd1;
          end
        end
      endcase
      // shadow writes from software become the values restored
      if (WR && shadow_sel && state != ST_VECTOR) begin
        case (ADDR)
          `OFS_SHD_ACC: shd_acc <= WDATA;
          `OFS_SHD_STATUS: shd_status <= WDATA & `STATUS_KEEP_MASK;
          `OFS_SHD_BANK_SEL: shd_bank_sel <= WDATA;
          `OFS_SHD_PTR_LO: shd_ind_ptr[7:0] <= WDATA;
          `OFS_SHD_PTR_HI: shd_ind_ptr[15:8] <= WDATA;
          `OFS_SHD_PCH: shd_pch <= WDATA;
          default: ;
        endcase
      end
    end
  end

  // return strobe: pop and restore in one cycle
  always @(posedge SYS_CLK) begin
    if (!RSTN) begin
      POP <= 1'b0;
      RESTORE <= 1'b0;
      RESTORE_ACC <= 8'h00;
      RESTORE_STATUS <= 8'h00;
      RESTORE_BANK_SEL <= 8'h00;
      RESTORE_IND_PTR <= 16'h0000;
      RESTORE_PCH <= 8'h00;
    end else begin
      POP <= RETURN_EXEC;
      RESTORE <= RETURN_EXEC;
      if (RETURN_EXEC) begin
        RESTORE_ACC <= shd_acc;
        // live timeout and power-down bits are kept by the core
        RESTORE_STATUS <= (shd_status & `STATUS_KEEP_MASK) |
                          (LIVE_STATUS & `STATUS_TOPD_MASK);
        RESTORE_BANK_SEL <= shd_bank_sel;
        RESTORE_IND_PTR <= shd_ind_ptr;
        RESTORE_PCH <= shd_pch;
      end
    end
  end

  // read port: data stand one cycle after the strobe, zero otherwise
  always @(posedge SYS_CLK) begin
    if (!RSTN) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `OFS_IRQ_CONTROL: RDATA <= ctrl;
        `OFS_OPTION: RDATA <= {6'h00, option};
        `OFS_CORE_STATE: RDATA <= {5'h00, take_pending, state};
        `OFS_SHD_ACC: RDATA <= shadow_sel ? shd_acc : 8'h00;
        `OFS_SHD_STATUS: RDATA <= shadow_sel ? shd_status : 8'h00;
        `OFS_SHD_BANK_SEL: RDATA <= shadow_sel ? shd_bank_sel : 8'h00;
        `OFS_SHD_PTR_LO: RDATA <= shadow_sel ? shd_ind_ptr[7:0] : 8'h00;
        `OFS_SHD_PTR_HI: RDATA <= shadow_sel ? shd_ind_ptr[15:8] : 8'h00;
        `OFS_SHD_PCH: RDATA <= shadow_sel ? shd_pch : 8'h00;
        default: RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end
endmodule

//--- testbench/irq_ctrl_chk_asserts.sv
// port checker for the interrupt control core
// assumes binding onto irq_ctrl_core, one clock domain
`timescale 1ns/1ps
module irq_ctrl_chk (
  input wire SYS_CLK, input wire RSTN, input wire RETURN_EXEC, input wire [7:0] LIVE_STATUS,
  input wire ASLEEP, input wire WAKE, input wire FLUSH, input wire FORCE_NOP, input wire PUSH,
  input wire POP, input wire LOAD_PC, input wire [14:0] NEW_PC, input wire RESTORE,
  input wire [7:0] RESTORE_STATUS
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  property p_vec; LOAD_PC |-> NEW_PC == 15'h0004; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_entry; PUSH |-> FLUSH && FORCE_NOP; endproperty
  a_entry: assert property (p_entry) else $error("entry incomplete");
  property p_lat; PUSH |-> ##[1:12] LOAD_PC; endproperty
  a_lat: assert property (p_lat) else $error("vector late");
  property p_nops; $rose(FORCE_NOP) |-> FORCE_NOP [*4]; endproperty
  a_nops: assert property (p_nops) else $error("nop fill short");
  property p_nop_end; LOAD_PC |-> ##[0:1] !FORCE_NOP; endproperty
  a_nop_end: assert property (p_nop_end) else $error("nop fill stuck");
  property p_ret; RETURN_EXEC |=> POP && RESTORE; endproperty
  a_ret: assert property (p_ret) else $error("no pop on return");
  property p_stat; RESTORE |-> RESTORE_STATUS[4:3] == $past(LIVE_STATUS[4:3]); endproperty
  a_stat: assert property (p_stat) else $error("status bits restored");
  property p_wake; WAKE |-> $past(ASLEEP) ##1 !ASLEEP; endproperty
  a_wake: assert property (p_wake) else $error("bad wake");
  c_push: cover property (PUSH);
  c_pop: cover property (POP);
  c_wake: cover property (WAKE);
endmodule
bind irq_ctrl_core irq_ctrl_chk irq_ctrl_chk_inst (.*);

//--- testbench/core_model.sv
// behavioural core: phase strobes and live context that restore reloads
// assumes four clocks per instruction cycle
`timescale 1ns/1ps
module core_model (
  input wire sys_clk, input wire rstn, input wire modify, input wire restore,
  input wire [7:0] r_acc, input wire [7:0] r_status, input wire [7:0] r_bank_sel,
  output logic q1, output logic retire,
  output logic [7:0] acc, output logic [7:0] status, output logic [7:0] bank_sel
);
  logic [1:0] ph;
  always @(posedge sys_clk) begin
    if (!rstn) begin
      ph <= 2'd0;
      {acc, status, bank_sel} <= {8'h3c, 8'h1b, 8'h05};
    end else begin
      ph <= ph + 2'd1;
      if (restore) {acc, status, bank_sel} <= {r_acc, r_status, r_bank_sel};
      // routine scribbling on live context, later lost
      else if (modify) {acc, status, bank_sel} <= ~{acc, status, bank_sel};
    end
  end
  assign q1 = rstn && ph == 2'd0;
  assign retire = rstn && ph == 2'd3;
endmodule

//--- testbench/tb_top.sv
// bench for the interrupt control core: register tasks and event sequences
// assumes core_model as the processor, a 200 MHz clock
`timescale 1ns/1ps
`include "irq_ctrl_regs.vh"
module tb_top;
  logic sys_clk = 0, rstn = 0, wr = 0, rd = 0, pin = 0, t0 = 0, pc_any = 0, ret = 0, slp = 0;
  logic modify = 0, periph = 0, q1, retire, asleep, push, restore;
  logic [3:0] addr = 0;
  logic [7:0] wdata = 0, rdata, acc, status, bank_sel, r_acc, r_status, r_bank_sel, r_pch;
  logic [15:0] r_ptr;
  logic [4:0] bank = 5'h1f;
  logic [14:0] push_pc;
  logic [7:0] sh [1:6] = '{8'h3c, 8'h03, 8'h05, 8'h34, 8'h12, 8'h07};
  int n_fail = 0, total_checks = 0, n_push = 0, i;
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (push === 1'b1) n_push <= n_push + 1;
  irq_ctrl_core irq_ctrl_core_inst (.SYS_CLK(sys_clk), .RSTN(rstn), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .BANK(bank), .EXT_PIN(pin),
    .TIMER0_OVF(t0), .PIN_CHANGE_ANY(pc_any), .PERIPH_REQ(periph), .Q1(q1), .RETIRE(retire),
    .RETURN_EXEC(ret), .SLEEP_ENTER(slp), .PC_RETURN(15'h0123), .LIVE_ACC(acc),
    .LIVE_STATUS(status), .LIVE_BANK_SEL(bank_sel), .LIVE_IND_PTR(16'h1234), .LIVE_PCH(8'h07),
    .ASLEEP(asleep), .WAKE(), .FLUSH(), .FORCE_NOP(), .PUSH(push), .PUSH_PC(push_pc),
    .POP(), .LOAD_PC(), .NEW_PC(), .RESTORE(restore), .RESTORE_ACC(r_acc),
    .RESTORE_STATUS(r_status), .RESTORE_BANK_SEL(r_bank_sel), .RESTORE_IND_PTR(r_ptr),
    .RESTORE_PCH(r_pch));
  core_model core_model_inst (.*);
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task wr_reg(input logic [3:0] a, input logic [7:0] v);
    cyc(1);
    wr <= 1;
    addr <= a;
    wdata <= v;
    cyc(1);
    wr <= 0;
  endtask
  task rd_reg(input logic [3:0] a, input logic [7:0] e);
    cyc(1);
    rd <= 1;
    addr <= a;
    cyc(1);
    rd <= 0;
    // data stand until the nba of this edge replaces them
    cyc(1);
    chk(rdata, e);
  endtask
  task wt_push(input int n0);
    for (i = 0; i < 40 && n_push == n0; i++) cyc(1);
    chk(16'(n_push), 16'(n0 + 1));
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    end_sim;
  end
  initial begin
    cyc(8);
    rstn <= 1;
    rd_reg(0, 8'h00);
    rd_reg(4'hf, 8'h00);
    wr_reg(0, 8'h7f);
    rd_reg(0, 8'h7e);
    wr_reg(0, 8'h00);
    wr_reg(`OFS_OPTION, 8'h01);
    t0 <= 1;
    pin <= 1;
    pc_any <= 1;
    cyc(1);
    t0 <= 0;
    cyc(6);
    rd_reg(0, 8'h07);
    wr_reg(0, 8'h00);
    rd_reg(0, 8'h01);
    pc_any <= 0;
    cyc(6);
    rd_reg(0, 8'h00);
    wr_reg(`OFS_OPTION, 8'h00);
    pin <= 0;
    cyc(6);
    rd_reg(0, 8'h02);
    wr_reg(0, 8'h00);
    pin <= 1;
    cyc(6);
    rd_reg(0, 8'h00);
    $display("flag tests done");
    wr_reg(`OFS_OPTION, 8'h01);
    pin <= 0;
    wr_reg(0, 8'h90);
    pin <= 1;
    wt_push(0);
    chk(push_pc, 15'h0123);
    rd_reg(0, 8'h12);
    for (int k = 1; k < 7; k++) rd_reg(4'(k), sh[k]);
    bank <= 5'h00;
    rd_reg(`OFS_SHD_ACC, 8'h00);
    bank <= 5'h1f;
    wr_reg(`OFS_SHD_ACC, 8'hc3);
    rd_reg(`OFS_SHD_ACC, 8'hc3);
    wr_reg(0, 8'h10);
    modify <= 1;
    cyc(1);
    modify <= 0;
    ret <= 1;
    cyc(1);
    ret <= 0;
    cyc(3);
    chk(acc, 8'hc3);
    chk(bank_sel, 8'h05);
    chk(r_ptr, 16'h1234);
    chk(r_pch, 8'h07);
    rd_reg(0, 8'h90);
    $display("entry and return done");
    wr_reg(0, 8'h20);
    t0 <= 1;
    cyc(1);
    t0 <= 0;
    cyc(20);
    chk(16'(n_push), 16'd1);
    wr_reg(0, 8'ha4);
    wt_push(1);
    cyc(12);
    // routine clears its flag, or return would re-enter at once
    wr_reg(0, 8'h00);
    ret <= 1;
    cyc(1);
    ret <= 0;
    wr_reg(0, 8'h30);
    slp <= 1;
    cyc(1);
    slp <= 0;
    t0 <= 1;
    cyc(1);
    t0 <= 0;
    cyc(8);
    chk(asleep, 1'b1);
    wr_reg(0, 8'h30);
    pin <= 0;
    cyc(6);
    pin <= 1;
    cyc(12);
    chk(asleep, 1'b0);
    chk(16'(n_push), 16'd2);
    pin <= 0;
    wr_reg(0, 8'h90);
    slp <= 1;
    cyc(1);
    slp <= 0;
    pin <= 1;
    wt_push(2);
    $display("sleep tests done");
    cyc(12);
    wr_reg(0, 8'h00);
    ret <= 1;
    cyc(1);
    ret <= 0;
    periph <= 1;
    cyc(12);
    chk(16'(n_push), 16'd3);
    wr_reg(0, 8'hc0);
    wt_push(3);
    periph <= 0;
    $display("peripheral tests done");
    end_sim;
  end
endmodule
